// File: rtl/ptk_pkg.sv
package ptk_pkg;

  // ==========================================================
  // Sequence sizes
  localparam int PAT_BITS = 64;
  localparam int XFER_BITS = 64;
  localparam int REG_COUNT = 8;
  localparam logic [5:0] PTR_LAST = 6'h3f;

  // Byte 0 goes first, least significant bit first
  localparam logic [63:0] UNLOCK_PATTERN =
    {8'ha3, 8'h5c, 8'ha3, 8'h3a, 8'hc5, 8'h5c, 8'h3a, 8'hc5};

  // ==========================================================
  // Time base
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // ==========================================================
  // Register indices and control bits
  localparam int REG_HUND = 0;
  localparam int REG_SEC = 1;
  localparam int REG_MIN = 2;
  localparam int REG_HOUR = 3;
  localparam int REG_DAY = 4;
  localparam int REG_DATE = 5;
  localparam int REG_MONTH = 6;
  localparam int REG_YEAR = 7;
  localparam int HOUR_12H_BIT = 7;
  localparam int HOUR_PM_BIT = 5;
  localparam int DAY_RST_IGN_BIT = 4;
  localparam int DAY_OSC_OFF_BIT = 5;

  // Reset values; reset-ignore and oscillator-off start set
  localparam logic [63:0] TIME_RESET =
    {8'h00, 8'h01, 8'h01, 8'h31, 8'h00, 8'h00, 8'h00, 8'h00};

  // ==========================================================
  // BCD limits
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_DEC = 8'h12;
  localparam logic [7:0] BCD_FEB = 8'h02;
  localparam logic [7:0] BCD_APR = 8'h04;
  localparam logic [7:0] BCD_JUN = 8'h06;
  localparam logic [7:0] BCD_SEP = 8'h09;
  localparam logic [7:0] BCD_NOV = 8'h11;
  localparam logic [7:0] DIM_28 = 8'h28;
  localparam logic [7:0] DIM_29 = 8'h29;
  localparam logic [7:0] DIM_30 = 8'h30;
  localparam logic [7:0] DIM_31 = 8'h31;
  localparam logic [5:0] HOUR24_LAST = 6'h23;
  localparam logic [4:0] HOUR12_TOP = 5'h12;
  localparam logic [4:0] HOUR12_PRE = 5'h11;
  localparam logic [4:0] HOUR12_FIRST = 5'h01;
  localparam logic [2:0] DAY_LAST = 3'h7;
  localparam logic [2:0] DAY_FIRST = 3'h1;

  // ==========================================================
  // Pin synchroniser idle: {ce_n, oe_n, we_n, bit, supply_ok, reset_n}
  localparam logic [5:0] PIN_IDLE = 6'h3d;

  // Host bus cycle timing in clocks; covers the device's pin sync delay
  localparam int CYC_ACTIVE = 10;
  localparam int CYC_GAP = 4;

  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_MATCH = 3'b010,
    ST_XFER = 3'b100
  } ptk_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_ACT = 3'b010,
    H_GAP = 3'b100
  } ptk_hstate_t;

endpackage

// File: rtl/ptk_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ptk_bus_if;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic host_bit_o;
  logic host_bit_oe;
  logic dev_bit_o;
  logic dev_bit_oe;
  logic serial_bit_line;

  // Pulled high when nobody drives
  assign serial_bit_line = dev_bit_oe ? dev_bit_o : (host_bit_oe ? host_bit_o : 1'h1);

  modport host (
    output ce_n, oe_n, we_n, host_bit_o, host_bit_oe,
    input serial_bit_line
  );
  modport dev (
    input ce_n, oe_n, we_n, serial_bit_line,
    output dev_bit_o, dev_bit_oe
  );
endinterface
`default_nettype wire

// File: rtl/ptk_dev.sv
// Notes on behaviour
// - Unlock needs 64 consecutive matching writes
// - Before unlock all cycles reach the RAM while supply is good
// - Next 64 cycles transfer; RAM enable suppressed
// - A read starts recognition at bit zero
// - Addresses are ignored entirely
// - Host should use one scratch RAM address
// - First write compares against pattern bit 0
// - Match advances pointer, await next write
// - Mismatch freezes until next read
// - Read during recognition resets the pointer
// - Reads drive bit line, writes capture it
// - Cycles without chip enable change nothing
// - Bad supply blocks RAM writes unconditionally
// - BCD calendar with month length, leap years
// - Twelve and twenty-four hour formats
// - Only supply and four strobes control
// - Pattern bytes sent least bit first
// - Transfer walks eight registers bit 0 up
// - Reset pin aborts transfer unless ignored
// - Hour bit 7 selects 12h; bit 5 PM
`timescale 1ns/1ns
`default_nettype none
module ptk_dev #(
  parameter int TICK_CYCLES = ptk_pkg::TICK_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  ptk_bus_if.dev bus,
  input wire logic supply_ok_i,
  input wire logic reset_pin_n_i,
  output logic mem_ce_n_o,
  output logic unlocked_o,
  output logic [63:0] time_o
);
  import ptk_pkg::*;

  // ==========================================================
  // Pin synchronisers; only the second stage is read
  logic [5:0] pin_s1_ff;
  logic [5:0] pin_s2_ff;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_s1_ff <= PIN_IDLE;
      pin_s2_ff <= PIN_IDLE;
    end else begin
      pin_s1_ff <= {bus.ce_n, bus.oe_n, bus.we_n, bus.serial_bit_line,
                    supply_ok_i, reset_pin_n_i};
      pin_s2_ff <= pin_s1_ff;
    end
  end
  wire ce_n_s = pin_s2_ff[5];
  wire oe_n_s = pin_s2_ff[4];
  wire we_n_s = pin_s2_ff[3];
  wire bit_s = pin_s2_ff[2];
  wire supply_s = pin_s2_ff[1];
  wire rst_pin_n_s = pin_s2_ff[0];

  // ==========================================================
  // Bus cycle tracking; address lines never enter the block
  logic act_ff;
  logic wr_seen_ff;
  logic wbit_ff;
  wire cyc_act = ~ce_n_s & (~oe_n_s | ~we_n_s) & supply_s;
  wire cyc_end = act_ff & ~cyc_act;
  wire end_rd = cyc_end & ~wr_seen_ff;
  wire end_wr = cyc_end & wr_seen_ff;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      act_ff <= 1'h0;
      wr_seen_ff <= 1'h0;
      wbit_ff <= 1'h0;
    end else begin
      act_ff <= cyc_act;
      wr_seen_ff <= cyc_act & (wr_seen_ff | ~we_n_s);
      // Last level seen while write is active is the closing-edge value
      if (cyc_act && !we_n_s) wbit_ff <= bit_s;
    end
  end

  // ==========================================================
  // Recognition and transfer sequencer
  ptk_state_t state_ff, nxt_state;
  logic [5:0] ptr_ff, nxt_ptr;
  logic [5:0] cnt_ff, nxt_cnt;
  logic [63:0] time_ff, nxt_time;
  logic [63:0] shad_ff;
  logic [7:0] wbyte_ff;
  wire in_xfer = (state_ff == ST_XFER);
  wire abort = in_xfer & ~rst_pin_n_s & ~time_ff[8*REG_DAY + DAY_RST_IGN_BIT];
  wire pat_hit = (wbit_ff == UNLOCK_PATTERN[ptr_ff]);
  wire unlock_done = (state_ff == ST_MATCH) & end_wr & pat_hit & (ptr_ff == PTR_LAST);
  wire xfer_last = in_xfer & cyc_end & (cnt_ff == PTR_LAST) & ~abort;
  wire xfer_wr = in_xfer & end_wr & ~abort;
  wire [7:0] wr_now = xfer_wr ? (8'h01 << cnt_ff[5:3]) : 8'h00;

  always_comb begin
    nxt_state = state_ff;
    nxt_ptr = ptr_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      ST_WAIT: begin
        if (end_rd) begin
          nxt_state = ST_MATCH;
          nxt_ptr = '0;
        end
      end
      ST_MATCH: begin
        if (end_rd) begin
          nxt_ptr = '0;
        end else if (end_wr) begin
          if (!pat_hit) begin
            nxt_state = ST_WAIT;
          end else if (ptr_ff == PTR_LAST) begin
            nxt_state = ST_XFER;
            nxt_cnt = '0;
          end else begin
            nxt_ptr = ptr_ff + 6'h01;
          end
        end
      end
      ST_XFER: begin
        if (abort) begin
          nxt_state = ST_WAIT;
          nxt_ptr = '0;
        end else if (cyc_end) begin
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == PTR_LAST) begin
            nxt_state = ST_WAIT;
            nxt_ptr = '0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= ST_WAIT;
      ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      ptr_ff <= nxt_ptr;
      cnt_ff <= nxt_cnt;
    end
  end

  // Reads see a frozen copy so a tick mid-window cannot tear the value
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      shad_ff <= '0;
    end else if (unlock_done) begin
      shad_ff <= time_ff;
    end else if (xfer_wr) begin
      shad_ff[cnt_ff] <= wbit_ff;
    end
  end

  // Only whole bytes touched by a write are committed
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi++) begin : g_wbyte
      always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          wbyte_ff[gi] <= 1'h0;
        end else if (unlock_done || abort) begin
          wbyte_ff[gi] <= 1'h0;
        end else if (wr_now[gi]) begin
          wbyte_ff[gi] <= 1'h1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Time base and BCD calendar
  logic [31:0] div_ff;
  wire osc_on = ~time_ff[8*REG_DAY + DAY_OSC_OFF_BIT];
  wire tick = osc_on & (div_ff == 32'(TICK_CYCLES - 1));
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) div_ff <= '0;
    else if (!osc_on || tick) div_ff <= '0;
    else div_ff <= div_ff + 32'h1;
  end

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  function automatic logic [7:0] roll(input logic [7:0] v, input logic [7:0] last,
                                      input logic [7:0] first);
    roll = (v == last) ? first : bcd_inc(v);
  endfunction

  wire [7:0] hund = time_ff[8*REG_HUND +: 8];
  wire [7:0] sec = time_ff[8*REG_SEC +: 8];
  wire [7:0] mins = time_ff[8*REG_MIN +: 8];
  wire [7:0] hour = time_ff[8*REG_HOUR +: 8];
  wire [7:0] day = time_ff[8*REG_DAY +: 8];
  wire [7:0] date = time_ff[8*REG_DATE +: 8];
  wire [7:0] month = time_ff[8*REG_MONTH +: 8];
  wire [7:0] year = time_ff[8*REG_YEAR +: 8];
  wire mode12 = hour[HOUR_12H_BIT];
  wire pm = hour[HOUR_PM_BIT];
  // Leap when year mod 4 is zero: even tens with 0/4/8, odd tens with 2/6
  wire leap = (year[4] == 1'h0) ? (year[3:0] == 4'h0 || year[3:0] == 4'h4 ||
              year[3:0] == 4'h8) : (year[3:0] == 4'h2 || year[3:0] == 4'h6);
  wire [7:0] dim = (month == BCD_FEB) ? (leap ? DIM_29 : DIM_28) :
                   (month == BCD_APR || month == BCD_JUN || month == BCD_SEP ||
                    month == BCD_NOV) ? DIM_30 : DIM_31;
  wire c_sec = tick & (hund == BCD_99);
  wire c_min = c_sec & (sec == BCD_59);
  wire c_hour = c_min & (mins == BCD_59);
  wire hour_wrap = mode12 ? (pm && hour[4:0] == HOUR12_PRE) : (hour[5:0] == HOUR24_LAST);
  wire c_day = c_hour & hour_wrap;
  wire c_month = c_day & (date == dim);
  wire c_year = c_month & (month == BCD_DEC);

  // 12h: 11 -> 12 flips the meridiem, 12 -> 01 keeps it
  wire [7:0] hour12_nxt = (hour[4:0] == HOUR12_TOP) ? {hour[7:5], HOUR12_FIRST} :
                          (hour[4:0] == HOUR12_PRE) ? {hour[7:6], ~pm, HOUR12_TOP} :
                          {hour[7:5], 5'(bcd_inc({3'h0, hour[4:0]}))};
  wire [7:0] hour24_nxt = (hour[5:0] == HOUR24_LAST) ? {hour[7:6], 6'h00} :
                          {hour[7:6], 6'(bcd_inc({2'h0, hour[5:0]}))};
  wire [2:0] day_nxt = (day[2:0] == DAY_LAST) ? DAY_FIRST : day[2:0] + 3'h1;

  always_comb begin
    nxt_time = time_ff;
    if (tick) nxt_time[8*REG_HUND +: 8] = roll(hund, BCD_99, BCD_ZERO);
    if (c_sec) nxt_time[8*REG_SEC +: 8] = roll(sec, BCD_59, BCD_ZERO);
    if (c_min) nxt_time[8*REG_MIN +: 8] = roll(mins, BCD_59, BCD_ZERO);
    if (c_hour) nxt_time[8*REG_HOUR +: 8] = mode12 ? hour12_nxt : hour24_nxt;
    if (c_day) nxt_time[8*REG_DAY +: 8] = {day[7:3], day_nxt};
    if (c_day) nxt_time[8*REG_DATE +: 8] = roll(date, dim, BCD_ONE);
    if (c_month) nxt_time[8*REG_MONTH +: 8] = roll(month, BCD_DEC, BCD_ONE);
    if (c_year) nxt_time[8*REG_YEAR +: 8] = roll(year, BCD_99, BCD_ZERO);
    // A committed write wins over the tick for its byte
    for (int i = 0; i < REG_COUNT; i++) begin
      if (xfer_last && (wbyte_ff[i] || wr_now[i])) nxt_time[8*i +: 8] = shad_ff[8*i +: 8];
    end
    // The closing bit has not reached the shadow yet
    if (xfer_last && xfer_wr) nxt_time[cnt_ff] = wbit_ff;
  end

  // ==========================================================
  // Outputs, all registered
  logic mem_ce_n_ff;
  logic bit_o_ff;
  logic bit_oe_ff;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      time_ff <= TIME_RESET;
      mem_ce_n_ff <= 1'h1;
      bit_o_ff <= 1'h0;
      bit_oe_ff <= 1'h0;
    end else begin
      time_ff <= nxt_time;
      // Pass-through unless transferring or supply is bad
      mem_ce_n_ff <= ce_n_s | (nxt_state == ST_XFER) | ~supply_s;
      bit_o_ff <= shad_ff[cnt_ff];
      bit_oe_ff <= in_xfer & cyc_act & ~oe_n_s & we_n_s & ~abort;
    end
  end

  assign mem_ce_n_o = mem_ce_n_ff;
  assign bus.dev_bit_o = bit_o_ff;
  assign bus.dev_bit_oe = bit_oe_ff;
  assign unlocked_o = state_ff[2];
  assign time_o = time_ff;
endmodule
`default_nettype wire

// File: rtl/ptk_host.sv
`timescale 1ns/1ns
`default_nettype none
module ptk_host #(
  parameter int CYC_ACTIVE = ptk_pkg::CYC_ACTIVE,
  parameter int CYC_GAP = ptk_pkg::CYC_GAP
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  ptk_bus_if.host bus,
  input wire logic unlock_i,
  input wire logic cyc_req_i,
  input wire logic cyc_write_i,
  input wire logic cyc_bit_i,
  output logic busy_o,
  output logic done_o,
  output logic rd_bit_o
);
  import ptk_pkg::*;

  // ==========================================================
  // Bit line synchroniser
  logic bit_s1_ff;
  logic bit_s2_ff;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_s1_ff <= 1'h1;
      bit_s2_ff <= 1'h1;
    end else begin
      bit_s1_ff <= bus.serial_bit_line;
      bit_s2_ff <= bit_s1_ff;
    end
  end

  // ==========================================================
  // Cycle engine; the unlock run is one read then 64 pattern writes
  ptk_hstate_t st_ff;
  logic [7:0] tmr_ff;
  logic seq_ff;
  logic [6:0] idx_ff;
  logic wr_ff;
  logic ce_n_ff;
  logic oe_n_ff;
  logic we_n_ff;
  logic dq_ff;
  logic dq_oe_ff;
  logic done_ff;
  logic rd_ff;
  logic busy_ff;

  wire act_end = (st_ff == H_ACT) && (tmr_ff == 8'(CYC_ACTIVE - 1));
  wire gap_end = (st_ff == H_GAP) && (tmr_ff == 8'(CYC_GAP - 1));
  wire seq_more = seq_ff && (idx_ff != 7'(PAT_BITS));
  wire start_rd = (st_ff == H_IDLE) && (unlock_i || (cyc_req_i && !cyc_write_i));
  wire start_wr = (gap_end && seq_more) || ((st_ff == H_IDLE) && !unlock_i &&
                  cyc_req_i && cyc_write_i);
  wire wr_bit = seq_more ? UNLOCK_PATTERN[idx_ff[5:0]] : cyc_bit_i;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff <= H_IDLE;
      tmr_ff <= '0;
      seq_ff <= 1'h0;
      idx_ff <= '0;
      wr_ff <= 1'h0;
      ce_n_ff <= 1'h1;
      oe_n_ff <= 1'h1;
      we_n_ff <= 1'h1;
      dq_ff <= 1'h0;
      dq_oe_ff <= 1'h0;
      done_ff <= 1'h0;
      rd_ff <= 1'h0;
      busy_ff <= 1'h0;
    end else begin
      done_ff <= 1'h0;
      if (start_rd || start_wr) begin
        st_ff <= H_ACT;
        tmr_ff <= '0;
        busy_ff <= 1'h1;
        wr_ff <= start_wr;
        ce_n_ff <= 1'h0;
        oe_n_ff <= ~start_rd;
        we_n_ff <= ~start_wr;
        dq_ff <= wr_bit;
        dq_oe_ff <= start_wr;
        if (start_rd && unlock_i) begin
          seq_ff <= 1'h1;
          idx_ff <= '0;
        end else if (start_wr && seq_more) begin
          idx_ff <= idx_ff + 7'h01;
        end
      end else if (act_end) begin
        st_ff <= H_GAP;
        tmr_ff <= '0;
        ce_n_ff <= 1'h1;
        oe_n_ff <= 1'h1;
        we_n_ff <= 1'h1;
        dq_oe_ff <= 1'h0;
        if (!wr_ff) rd_ff <= bit_s2_ff;
      end else if (gap_end) begin
        st_ff <= H_IDLE;
        busy_ff <= 1'h0;
        done_ff <= 1'h1;
        seq_ff <= 1'h0;
      end else if (st_ff != H_IDLE) begin
        tmr_ff <= tmr_ff + 8'h01;
      end
    end
  end

  assign bus.ce_n = ce_n_ff;
  assign bus.oe_n = oe_n_ff;
  assign bus.we_n = we_n_ff;
  assign bus.host_bit_o = dq_ff;
  assign bus.host_bit_oe = dq_oe_ff;
  assign busy_o = busy_ff;
  assign done_o = done_ff;
  assign rd_bit_o = rd_ff;
endmodule
`default_nettype wire

// File: test/ptk_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ptk_chk (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic host_bit_oe,
  input wire logic dev_bit_oe,
  input wire logic supply_ok_i,
  input wire logic mem_ce_n_o,
  input wire logic unlocked_o
);
  // ==========================================================
  // Window cycle counter
  logic ce_q_ff;
  logic [6:0] win_cnt_ff;
  logic [6:0] nxt_win_cnt;
  wire logic ce_closed = ce_n && !ce_q_ff;

  assign nxt_win_cnt = !unlocked_o ? 7'h00 : (ce_closed ? win_cnt_ff + 7'h01 : win_cnt_ff);

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ce_q_ff <= 1'h1;
      win_cnt_ff <= 7'h00;
    end else begin
      ce_q_ff <= ce_n;
      win_cnt_ff <= nxt_win_cnt;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  property p_drive_excl;
    !(dev_bit_oe && host_bit_oe);
  endproperty
  a_drive_excl: assert property (p_drive_excl) else $error("both ends drive the bit line");

  property p_dev_on_read;
    $rose(dev_bit_oe) |-> unlocked_o && !ce_n && !oe_n && we_n;
  endproperty
  a_dev_on_read: assert property (p_dev_on_read) else $error("device drives outside a read");

  property p_dev_release;
    $rose(oe_n) |-> ##[1:5] !dev_bit_oe;
  endproperty
  a_dev_release: assert property (p_dev_release) else $error("device holds the line");

  property p_dev_idle;
    (!unlocked_o) [*6] |-> !dev_bit_oe;
  endproperty
  a_dev_idle: assert property (p_dev_idle) else $error("device drives while locked");

  property p_win_ram;
    unlocked_o |-> mem_ce_n_o;
  endproperty
  a_win_ram: assert property (p_win_ram) else $error("RAM selected in window");

  property p_supply;
    (!supply_ok_i) [*4] |-> mem_ce_n_o;
  endproperty
  a_supply: assert property (p_supply) else $error("RAM selected on bad supply");

  property p_ce_follow;
    (supply_ok_i && !unlocked_o) [*6] |-> mem_ce_n_o == $past(ce_n, 3);
  endproperty
  a_ce_follow: assert property (p_ce_follow) else $error("RAM enable does not follow");

  property p_win_len;
    unlocked_o |-> win_cnt_ff <= 7'h40;
  endproperty
  a_win_len: assert property (p_win_len) else $error("window longer than 64");

  property p_unlock_idle;
    $rose(unlocked_o) |-> ce_n && we_n;
  endproperty
  a_unlock_idle: assert property (p_unlock_idle) else $error("unlock inside a cycle");

  property p_host_cyc;
    $fell(ce_n) && !oe_n |-> (!ce_n) [*8] ##1 (!ce_n) [*2] ##1 ce_n;
  endproperty
  a_host_cyc: assert property (p_host_cyc) else $error("read strobe length wrong");
endmodule
`default_nettype wire

// File: test/pattern_unlock_serial_clock_access_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module pattern_unlock_serial_clock_access_tb_top;
  import ptk_pkg::*;
  logic core_clk_i, reset_i, unlock, cyc_req, cyc_write, cyc_bit, supply_ok, reset_pin_n;
  logic busy, done, rd_bit, mem_ce_n, unlocked, sel;
  logic [63:0] time_val;
  int bad_count, checked, cycles;
  // Rollover cases: start value, then expected bytes above hundredths
  logic [63:0] roll_start [4] = '{64'h24_02_28_01_23_59_59_99, 64'h23_02_28_07_b1_59_59_99,
    64'h25_04_30_03_23_59_59_99, 64'h25_12_31_05_91_59_59_99};
  logic [55:0] roll_exp [4] = '{56'h24_02_29_02_00_00_00, 56'h23_03_01_01_92_00_00,
    56'h25_05_01_04_00_00_00, 56'h25_12_31_05_b2_00_00};
  localparam logic [63:0] WVAL = 64'h84_02_28_31_92_45_30_12;

  ptk_bus_if bus_if ();
  ptk_host ptk_host_inst (.core_clk_i(core_clk_i), .reset_i(reset_i), .bus(bus_if.host),
    .unlock_i(unlock), .cyc_req_i(cyc_req), .cyc_write_i(cyc_write), .cyc_bit_i(cyc_bit),
    .busy_o(busy), .done_o(done), .rd_bit_o(rd_bit));
  // Short tick keeps rollover checks quick
  ptk_dev #(.TICK_CYCLES(4)) ptk_dev_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .bus(bus_if.dev), .supply_ok_i(supply_ok), .reset_pin_n_i(reset_pin_n),
    .mem_ce_n_o(mem_ce_n), .unlocked_o(unlocked), .time_o(time_val));
  ptk_chk ptk_chk_inst (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_n(bus_if.ce_n),
    .oe_n(bus_if.oe_n), .we_n(bus_if.we_n), .host_bit_oe(bus_if.host_bit_oe),
    .dev_bit_oe(bus_if.dev_bit_oe), .supply_ok_i(supply_ok), .mem_ce_n_o(mem_ce_n),
    .unlocked_o(unlocked));

  // ==========================================================
  // Tasks
  task automatic give_verdict();
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // One host cycle, or the whole unlock run when unl is set; sel notes RAM selection
  task automatic cyc(input logic wr, input logic b, input logic unl);
    int n;
    n = 0;
    sel = 1'h0;
    @(posedge core_clk_i);
    unlock <= unl;
    cyc_req <= !unl;
    cyc_write <= wr;
    cyc_bit <= b;
    @(posedge core_clk_i);
    unlock <= 1'h0;
    cyc_req <= 1'h0;
    #1;
    chk(64'(busy), 64'h1);
    do begin
      @(posedge core_clk_i);
      #1;
      n++;
      if (mem_ce_n === 1'h0) sel = 1'h1;
    end while (done !== 1'h1 && n < 1200);
    if (n >= 1200) chk(64'(done), 64'h1);
    chk(64'(busy), 64'h0);
  endtask

  // Unlock writes carry no address, so all land on one scratch location
  task automatic send_pat(input int n);
    for (int i = 0; i < n; i++) cyc(1'h1, UNLOCK_PATTERN[i], 1'h0);
  endtask

  task automatic open_win();
    cyc(1'h0, 1'h0, 1'h1);
    settle(8);
    chk(64'(unlocked), 64'h1);
  endtask

  task automatic xfer(input logic wr, input logic [63:0] val);
    for (int i = 0; i < 64; i++) begin
      cyc(wr, val[i], 1'h0);
      chk(64'(sel), 64'h0);
      if (!wr) chk(64'(rd_bit), 64'(val[i]));
    end
    settle(8);
    chk(64'(unlocked), 64'h0);
  endtask

  // ==========================================================
  // Clock, timeout, main sequence
  initial begin
    core_clk_i = 1'h0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    reset_i = 1'h1;
    {unlock, cyc_req, cyc_write, cyc_bit, sel} = 5'h00;
    supply_ok = 1'h1;
    reset_pin_n = 1'h1;
    bad_count = 0;
    checked = 0;
    cycles = 0;
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'h0;
    cyc(1'h1, 1'h0, 1'h0);
    chk(64'(sel), 64'h1);
    cyc(1'h0, 1'h0, 1'h0);
    cyc(1'h1, ~UNLOCK_PATTERN[0], 1'h0);
    send_pat(64);
    settle(8);
    chk(64'(unlocked), 64'h0);
    cyc(1'h0, 1'h0, 1'h0);
    send_pat(10);
    cyc(1'h0, 1'h0, 1'h0);
    send_pat(64);
    settle(8);
    chk(64'(unlocked), 64'h1);
    xfer(1'h0, TIME_RESET);
    open_win();
    xfer(1'h1, WVAL);
    chk(time_val, WVAL);
    open_win();
    xfer(1'h0, WVAL);
    for (int k = 0; k < 4; k++) begin
      open_win();
      xfer(1'h1, roll_start[k]);
      settle(20);
      chk(64'(time_val[63:8]), 64'(roll_exp[k]));
    end
    // Reset-ignore is now clear, so the pin aborts the window
    open_win();
    for (int i = 0; i < 40; i++) cyc(1'h1, 1'h1, 1'h0);
    @(posedge core_clk_i);
    reset_pin_n <= 1'h0;
    repeat (6) @(posedge core_clk_i);
    reset_pin_n <= 1'h1;
    settle(8);
    chk(64'(unlocked), 64'h0);
    chk(64'(time_val[63:24]), 64'h25_12_31_05_b2);
    cyc(1'h0, 1'h0, 1'h0);
    chk(64'(sel), 64'h1);
    @(posedge core_clk_i);
    supply_ok <= 1'h0;
    settle(8);
    cyc(1'h1, 1'h1, 1'h0);
    chk(64'(sel), 64'h0);
    @(posedge core_clk_i);
    supply_ok <= 1'h1;
    settle(8);
    cyc(1'h1, 1'h0, 1'h0);
    chk(64'(sel), 64'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
